// ==== logic/scdc_params.svh ====
// Purpose: Offsets, field positions, reset values and codes of the card control bank
// Assumes: Byte-wide configuration accesses
// Notes: Included by the top module and by the checker
`ifndef SCDC_PARAMS_SVH
`define SCDC_PARAMS_SVH

`define SCDC_OFS_CARD_CTRL 8'h91
`define SCDC_OFS_DEV_CTRL 8'h92

`define SCDC_CARD_CTRL_RESET 8'h00
`define SCDC_DEV_CTRL_RESET 8'h66

// Card control field positions
`define SCDC_CC_RING_EN 7
`define SCDC_CC_VID_FLOAT 6
`define SCDC_CC_PRIO 5
`define SCDC_CC_AUD_MUX 2
`define SCDC_CC_CARD_SPEAKER_EN 1
`define SCDC_CC_IRQ_FLAG 0

// Device control field positions
`define SCDC_DC_LOW_VOLT 6
`define SCDC_DC_DIAG 5
`define SCDC_DC_TEST 3
`define SCDC_DC_MODE_HI 2
`define SCDC_DC_MODE_LO 1
`define SCDC_DC_RSVD_TEST 0

// Multifunction terminal selections
`define SCDC_MF_AUDIO_PWM 4'h8
`define SCDC_MF_RING_OUT 4'hC

`endif

// ==== logic/scdc_pkg.sv ====
// Purpose: Types shared by the card control bank
// Assumes: Two socket functions, numbered 0 and 1
// Notes: Constants live in scdc_params.svh
package scdc_pkg;

   typedef enum logic [1:0] {
      SCDC_MODE_PAR_HOST = 2'b00,
      SCDC_MODE_PAR_IRQ = 2'b01,
      SCDC_MODE_SER_IRQ = 2'b10,
      SCDC_MODE_SER_ALL = 2'b11
   } scdc_irq_mode_type;

   typedef struct packed {
      logic fn;
      logic [7:0] offset;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } scdc_cfg_req_type;

   typedef struct packed {
      logic ack;
      logic [7:0] rdata;
   } scdc_cfg_rsp_type;

endpackage : scdc_pkg

// ==== logic/scdc_sync2.sv ====
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk_sys
// Notes: First stage feeds only the second
`timescale 1ns/10ps
module scdc_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule : scdc_sync2

// ==== logic/scdc_irq_flag.sv ====
// Purpose: Sticky per-socket card interrupt flag
// Assumes: set_pulse and clear_pulse are on clk_sys
// Notes: A set in the clearing cycle wins
`timescale 1ns/10ps
module scdc_irq_flag (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic set_pulse,
   input wire logic clear_pulse,
   output logic flag_reg
);

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         flag_reg <= 1'b0;
      end else if (set_pulse) begin
         flag_reg <= 1'b1;
      end else if (clear_pulse) begin
         flag_reg <= 1'b0;
      end
   end

endmodule : scdc_irq_flag

// ==== logic/scdc_top.sv ====
// Purpose: Card control and device control configuration registers of a dual-socket bridge
// Assumes: Byte-wide configuration accesses on clk_sys; card pins asynchronous
// Notes: Ring enable, low-voltage and test bits are written through function 0 only, mode and diagnostic through either; all read from either
`timescale 1ns/10ps
`include "scdc_params.svh"

module scdc_top (
   input wire logic clk_sys,
   input wire logic rst_b,
   input scdc_pkg::scdc_cfg_req_type cfg_req,
   output scdc_pkg::scdc_cfg_rsp_type cfg_rsp,
   input wire logic [1:0] card_irq_pin,
   input wire logic [1:0] card_audio_in,
   input wire logic [1:0] card_speaker,
   input wire logic ring_indicate_src,
   input wire logic ring_pme_select,
   input wire logic [3:0] multifunction_terminal_2,
   input wire logic [3:0] multifunction_terminal_4,
   output logic ring_indicate_output,
   output logic ring_indicate_output_oe,
   output logic multifunction_terminal_2_out,
   output logic multifunction_terminal_2_oe,
   output logic mfunc4_out,
   output logic mfunc4_oe,
   output logic speaker_output,
   output logic speaker_output_oe,
   output logic [1:0] video_port_float,
   output logic video_select_socket0_b,
   output logic video_select_socket1_b,
   output logic low_volt_socket_force,
   output scdc_pkg::scdc_irq_mode_type irq_signaling_select,
   output logic legacy_io_diag_bit,
   output logic vendor_test_bit,
   output logic test_reserved_bit
);
   import scdc_pkg::*;

   // Reset words, split into their fields below
   localparam logic [7:0] CC_RESET = `SCDC_CARD_CTRL_RESET;
   localparam logic [7:0] DC_RESET = `SCDC_DEV_CTRL_RESET;

   // Per-function card control copies
   logic [1:0] video_float_reg;
   logic [1:0] prio_reg;
   logic [1:0] card_audio_to_mux_reg;
   logic [1:0] speaker_route_enable_reg;
   logic [1:0] card_irq_flag;

   // Global bits
   logic ring_out_enable_reg;
   logic low_volt_reg;
   logic diag_reg;
   logic test_reg;
   logic rsvd_test_reg;
   scdc_irq_mode_type mode_reg;

   // Synchronised pins
   logic [1:0] irq_sync;
   logic [1:0] audio_sync;
   logic [1:0] speaker_sync;
   logic ring_sync;
   logic [1:0] irq_last_reg;
   logic [1:0] irq_rise;

   // Decoded accesses
   logic hit_card;
   logic hit_dev;
   logic wr_card;
   logic wr_dev;
   logic fn0_access;
   logic [1:0] flag_clear;

   logic [7:0] card_view;
   logic [7:0] dev_view;
   logic [7:0] rdata_next;

   // Routing intermediates
   logic ring_gated;
   logic audio_pick;
   logic audio_any;
   logic speaker_mix;
   logic both_video;
   logic sel0_next;
   logic sel1_next;

   scdc_sync2 #(
      .WIDTH(7)
   ) u_pin_sync (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .async_in({ring_indicate_src, card_speaker, card_audio_in, card_irq_pin}),
      .sync_out({ring_sync, speaker_sync, audio_sync, irq_sync})
   );

   assign hit_card = cfg_req.offset == `SCDC_OFS_CARD_CTRL;
   assign hit_dev = cfg_req.offset == `SCDC_OFS_DEV_CTRL;
   assign wr_card = cfg_req.wr && hit_card;
   assign wr_dev = cfg_req.wr && hit_dev;
   assign fn0_access = !cfg_req.fn;

   // Interrupt edge detect on the synchronised level
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         irq_last_reg <= 2'h0;
      end else begin
         irq_last_reg <= irq_sync;
      end
   end

   assign irq_rise = irq_sync & ~irq_last_reg;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sock
         // Write of 1 to the flag bit of this function clears it
         assign flag_clear[gi] = wr_card && (cfg_req.fn == 1'(gi)) &&
            cfg_req.wdata[`SCDC_CC_IRQ_FLAG];

         scdc_irq_flag u_flag (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .set_pulse(irq_rise[gi]),
            .clear_pulse(flag_clear[gi]),
            .flag_reg(card_irq_flag[gi])
         );
      end
   endgenerate

   // Per-function copies of card control
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         video_float_reg <= 2'h0;
         prio_reg <= 2'h0;
         card_audio_to_mux_reg <= 2'h0;
         speaker_route_enable_reg <= 2'h0;
      end else if (wr_card) begin
         video_float_reg[cfg_req.fn] <= cfg_req.wdata[`SCDC_CC_VID_FLOAT];
         prio_reg[cfg_req.fn] <= cfg_req.wdata[`SCDC_CC_PRIO];
         card_audio_to_mux_reg[cfg_req.fn] <= cfg_req.wdata[`SCDC_CC_AUD_MUX];
         speaker_route_enable_reg[cfg_req.fn] <= cfg_req.wdata[`SCDC_CC_CARD_SPEAKER_EN];
      end
   end

   // Shared ring enable; function 1 writes leave it alone
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         ring_out_enable_reg <= CC_RESET[`SCDC_CC_RING_EN];
      end else if (wr_card && fn0_access) begin
         ring_out_enable_reg <= cfg_req.wdata[`SCDC_CC_RING_EN];
      end
   end

   // Global device control bits held only by function 0
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         low_volt_reg <= DC_RESET[`SCDC_DC_LOW_VOLT];
         test_reg <= DC_RESET[`SCDC_DC_TEST];
         rsvd_test_reg <= DC_RESET[`SCDC_DC_RSVD_TEST];
      end else if (wr_dev && fn0_access) begin
         low_volt_reg <= cfg_req.wdata[`SCDC_DC_LOW_VOLT];
         test_reg <= cfg_req.wdata[`SCDC_DC_TEST];
         rsvd_test_reg <= cfg_req.wdata[`SCDC_DC_RSVD_TEST];
      end
   end

   // Mode and diagnostic are one copy, writable through either function
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         diag_reg <= DC_RESET[`SCDC_DC_DIAG];
         mode_reg <= scdc_irq_mode_type'(DC_RESET[`SCDC_DC_MODE_HI:`SCDC_DC_MODE_LO]);
      end else if (wr_dev) begin
         diag_reg <= cfg_req.wdata[`SCDC_DC_DIAG];
         mode_reg <= scdc_irq_mode_type'(
            cfg_req.wdata[`SCDC_DC_MODE_HI:`SCDC_DC_MODE_LO]);
      end
   end

   // Read views; reserved bits tie to zero
   always_comb begin
      card_view = 8'h00;
      card_view[`SCDC_CC_RING_EN] = ring_out_enable_reg;
      card_view[`SCDC_CC_VID_FLOAT] = video_float_reg[cfg_req.fn];
      card_view[`SCDC_CC_PRIO] = prio_reg[cfg_req.fn];
      card_view[`SCDC_CC_AUD_MUX] = card_audio_to_mux_reg[cfg_req.fn];
      card_view[`SCDC_CC_CARD_SPEAKER_EN] = speaker_route_enable_reg[cfg_req.fn];
      card_view[`SCDC_CC_IRQ_FLAG] = card_irq_flag[cfg_req.fn];
   end

   always_comb begin
      dev_view = 8'h00;
      dev_view[`SCDC_DC_LOW_VOLT] = low_volt_reg;
      dev_view[`SCDC_DC_DIAG] = diag_reg;
      dev_view[`SCDC_DC_TEST] = test_reg;
      dev_view[`SCDC_DC_MODE_HI:`SCDC_DC_MODE_LO] = mode_reg;
      dev_view[`SCDC_DC_RSVD_TEST] = rsvd_test_reg;
   end

   always_comb begin
      rdata_next = 8'h00;
      if (cfg_req.rd && hit_card) begin
         rdata_next = card_view;
      end else if (cfg_req.rd && hit_dev) begin
         rdata_next = dev_view;
      end
   end

   // Every access is answered one cycle later; unmapped reads give zero
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cfg_rsp <= '0;
      end else begin
         cfg_rsp.ack <= cfg_req.rd || cfg_req.wr;
         cfg_rsp.rdata <= rdata_next;
      end
   end

   // Ring indicate routing
   assign ring_gated = ring_out_enable_reg && ring_sync;

   // Socket 0 audio wins when both functions route audio
   always_comb begin
      audio_pick = 1'b0;
      audio_any = |card_audio_to_mux_reg;
      if (card_audio_to_mux_reg[0]) begin
         audio_pick = audio_sync[0];
      end else if (card_audio_to_mux_reg[1]) begin
         audio_pick = audio_sync[1];
      end
   end

   assign speaker_mix = (speaker_sync[0] && speaker_route_enable_reg[0]) ^
      (speaker_sync[1] && speaker_route_enable_reg[1]);

   // Video select, low active; contention resolved by function 0 priority bit
   assign both_video = &video_float_reg;
   always_comb begin
      sel0_next = video_float_reg[0];
      sel1_next = video_float_reg[1];
      if (both_video) begin
         sel0_next = !prio_reg[0];
         sel1_next = prio_reg[0];
      end
   end

   // Pin drivers registered so outputs come from flip-flops
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         ring_indicate_output <= 1'b0;
         ring_indicate_output_oe <= 1'b0;
      end else begin
         ring_indicate_output <= ring_gated && !ring_pme_select;
         ring_indicate_output_oe <= ring_out_enable_reg && !ring_pme_select;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         multifunction_terminal_2_out <= 1'b0;
         multifunction_terminal_2_oe <= 1'b0;
      end else begin
         case (multifunction_terminal_2)
            `SCDC_MF_AUDIO_PWM: begin
               multifunction_terminal_2_out <= audio_pick;
               multifunction_terminal_2_oe <= audio_any;
            end
            `SCDC_MF_RING_OUT: begin
               multifunction_terminal_2_out <= ring_gated;
               multifunction_terminal_2_oe <= ring_out_enable_reg;
            end
            default: begin
               multifunction_terminal_2_out <= 1'b0;
               multifunction_terminal_2_oe <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         mfunc4_out <= 1'b0;
         mfunc4_oe <= 1'b0;
      end else begin
         case (multifunction_terminal_4)
            `SCDC_MF_AUDIO_PWM: begin
               mfunc4_out <= audio_pick;
               mfunc4_oe <= audio_any;
            end
            `SCDC_MF_RING_OUT: begin
               mfunc4_out <= ring_gated;
               mfunc4_oe <= ring_out_enable_reg;
            end
            default: begin
               mfunc4_out <= 1'b0;
               mfunc4_oe <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         speaker_output <= 1'b0;
         speaker_output_oe <= 1'b0;
      end else begin
         speaker_output <= speaker_mix;
         speaker_output_oe <= |speaker_route_enable_reg;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         video_select_socket0_b <= 1'b1;
         video_select_socket1_b <= 1'b1;
      end else begin
         video_select_socket0_b <= !sel0_next;
         video_select_socket1_b <= !sel1_next;
      end
   end

   // Straight register views
   assign video_port_float = video_float_reg;
   assign low_volt_socket_force = low_volt_reg;
   assign irq_signaling_select = mode_reg;
   assign legacy_io_diag_bit = diag_reg;
   assign vendor_test_bit = test_reg;
   assign test_reserved_bit = rsvd_test_reg;

endmodule : scdc_top

// ==== tb/scdc_socket_model.sv ====
// Purpose: Two card sockets driving interrupt, audio and speaker pins
// Assumes: Levels are chosen by the bench on clk_sys
// Notes: Pins move 3 ns after the edge, so they are never sampled mid-change
`timescale 1ns/10ps
module scdc_socket_model (
   input wire logic clk_sys,
   input wire logic [1:0] irq_lvl,
   input wire logic [1:0] aud_lvl,
   input wire logic [1:0] spk_lvl,
   output logic [1:0] card_irq_pin,
   output logic [1:0] card_audio_in,
   output logic [1:0] card_speaker
);
   initial begin
      {card_irq_pin, card_audio_in, card_speaker} = '0;
   end
   always @(posedge clk_sys) begin
      // Level interrupt held until the bench drops it
      card_irq_pin <= #3 irq_lvl;
      card_audio_in <= #3 aud_lvl;
      card_speaker <= #3 spk_lvl;
   end
endmodule : scdc_socket_model

// ==== tb/scdc_top_sva.sv ====
// Purpose: Port-level checks of the card and device control bank
// Assumes: Read data answers one cycle after the strobe
// Notes: Bound to scdc_top at the foot
`timescale 1ns/10ps
`include "scdc_params.svh"
module scdc_top_sva (
   input wire logic clk_sys,
   input wire logic rst_b,
   input scdc_pkg::scdc_cfg_req_type cfg_req,
   input scdc_pkg::scdc_cfg_rsp_type cfg_rsp,
   input wire logic ring_pme_select,
   input wire logic [3:0] multifunction_terminal_2,
   input wire logic ring_indicate_output_oe,
   input wire logic multifunction_terminal_2_oe,
   input wire logic speaker_output_oe,
   input wire logic [1:0] video_port_float,
   input wire logic video_select_socket0_b,
   input wire logic video_select_socket1_b,
   input wire logic low_volt_socket_force,
   input scdc_pkg::scdc_irq_mode_type irq_signaling_select,
   input wire logic legacy_io_diag_bit,
   input wire logic vendor_test_bit,
   input wire logic test_reserved_bit
);
   import scdc_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   property p_ack;
      cfg_rsp.ack == $past(cfg_req.rd || cfg_req.wr);
   endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle after request");
   property p_unmap;
      $past(cfg_req.rd) && !($past(cfg_req.offset) inside {8'h91, 8'h92}) |->
         cfg_rsp.rdata == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_cc;
      $past(cfg_req.rd) && $past(cfg_req.offset) == `SCDC_OFS_CARD_CTRL |->
         cfg_rsp.rdata[4:3] == 2'b00 &&
         cfg_rsp.rdata[6] == video_port_float[$past(cfg_req.fn)];
   endproperty
   a_cc: assert property (p_cc) else $error("card control read wrong");
   property p_dc_rsvd;
      $past(cfg_req.rd) && $past(cfg_req.offset) == `SCDC_OFS_DEV_CTRL |->
         !cfg_rsp.rdata[7] && !cfg_rsp.rdata[4];
   endproperty
   a_dc_rsvd: assert property (p_dc_rsvd) else $error("device control spare bits set");
   property p_dc_view;
      $past(cfg_req.rd) && $past(cfg_req.offset) == `SCDC_OFS_DEV_CTRL |->
         cfg_rsp.rdata[6:5] == {low_volt_socket_force, legacy_io_diag_bit} &&
         cfg_rsp.rdata[3:0] == {vendor_test_bit, irq_signaling_select, test_reserved_bit};
   endproperty
   a_dc_view: assert property (p_dc_view) else $error("dev view differs");
   property p_vsel_excl;
      video_select_socket0_b || video_select_socket1_b;
   endproperty
   a_vsel_excl: assert property (p_vsel_excl) else $error("both video selects low");
   property p_vsel_cause;
      (video_select_socket0_b || $past(video_port_float[0])) &&
      (video_select_socket1_b || $past(video_port_float[1]));
   endproperty
   a_vsel_cause: assert property (p_vsel_cause) else $error("select without float");
   property p_ring_pin;
      ring_indicate_output_oe |-> !$past(ring_pme_select);
   endproperty
   a_ring_pin: assert property (p_ring_pin) else $error("ring pin driven when muxed off");
   property p_mf2;
      multifunction_terminal_2_oe |-> $past(multifunction_terminal_2) inside {`SCDC_MF_AUDIO_PWM, `SCDC_MF_RING_OUT};
   endproperty
   a_mf2: assert property (p_mf2) else $error("terminal 2 driven for other code");
   c_spk: cover property (speaker_output_oe);
   c_prio1: cover property (!video_select_socket1_b && video_port_float == 2'b11);
   c_ring: cover property (multifunction_terminal_2_oe && ring_indicate_output_oe);
endmodule : scdc_top_sva
bind scdc_top scdc_top_sva chk (.clk_sys(clk_sys), .rst_b(rst_b), .cfg_req(cfg_req),
   .cfg_rsp(cfg_rsp), .ring_pme_select(ring_pme_select),
   .multifunction_terminal_2(multifunction_terminal_2),
   .ring_indicate_output_oe(ring_indicate_output_oe), .multifunction_terminal_2_oe(multifunction_terminal_2_oe),
   .speaker_output_oe(speaker_output_oe), .video_port_float(video_port_float),
   .video_select_socket0_b(video_select_socket0_b),
   .video_select_socket1_b(video_select_socket1_b),
   .low_volt_socket_force(low_volt_socket_force), .irq_signaling_select(irq_signaling_select),
   .legacy_io_diag_bit(legacy_io_diag_bit), .vendor_test_bit(vendor_test_bit),
   .test_reserved_bit(test_reserved_bit));

// ==== tb/scdc_top_tb.sv ====
// Purpose: Self-checking bench for the card and device control bank
// Assumes: One strobe per access, answer on the next edge
// Notes: Pin paths get 6 cycles to settle through the synchronisers
`timescale 1ns/10ps
module scdc_top_tb;
   import scdc_pkg::*;
   logic clk_sys, rst_b = 1'b0, ring_indicate_src = 1'b0, ring_pme_select = 1'b0;
   scdc_cfg_req_type cfg_req = '0;
   scdc_cfg_rsp_type cfg_rsp;
   logic [1:0] card_irq_pin, card_audio_in, card_speaker, vfloat;
   logic [1:0] irq_lvl = '0, aud_lvl = '0, spk_lvl = '0;
   logic [3:0] mf2 = '0, mf4 = '0;
   logic ring_o, ring_oe, m2_o, m2_oe, m4_o, m4_oe, spk_o, spk_oe, vs0_b, vs1_b;
   logic lv, diag, vtest, rtest, f, ring_en, lv_m, diag_m;
   scdc_irq_mode_type mode;
   logic [7:0] rd_v, d, cc0, cc1;
   int n_mismatch = 0, n_tests = 0, k;
   scdc_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
      .card_irq_pin(card_irq_pin), .card_audio_in(card_audio_in), .card_speaker(card_speaker),
      .ring_indicate_src(ring_indicate_src), .ring_pme_select(ring_pme_select),
      .multifunction_terminal_2(mf2), .multifunction_terminal_4(mf4),
      .ring_indicate_output(ring_o), .ring_indicate_output_oe(ring_oe),
      .multifunction_terminal_2_out(m2_o), .multifunction_terminal_2_oe(m2_oe), .mfunc4_out(m4_o), .mfunc4_oe(m4_oe),
      .speaker_output(spk_o), .speaker_output_oe(spk_oe), .video_port_float(vfloat),
      .video_select_socket0_b(vs0_b), .video_select_socket1_b(vs1_b),
      .low_volt_socket_force(lv), .irq_signaling_select(mode), .legacy_io_diag_bit(diag),
      .vendor_test_bit(vtest), .test_reserved_bit(rtest));
   scdc_socket_model sock (.clk_sys(clk_sys), .irq_lvl(irq_lvl), .aud_lvl(aud_lvl),
      .spk_lvl(spk_lvl), .card_irq_pin(card_irq_pin), .card_audio_in(card_audio_in),
      .card_speaker(card_speaker));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] ex);
      n_tests++;
      if (seen !== ex) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
      end
   endtask : chk
   task automatic stop_test();
      $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   // Strobe lasts one cycle; ack is looked at just after the answering edge
   task automatic bus(input logic fn, input logic [7:0] ofs, input logic w, input logic [7:0] wd);
      @(posedge clk_sys);
      cfg_req <= '{fn: fn, offset: ofs, wr: w, rd: !w, wdata: wd};
      @(posedge clk_sys);
      cfg_req.wr <= 1'b0;
      cfg_req.rd <= 1'b0;
      #1;
      chk("ack", cfg_rsp.ack, 1'b1);
      rd_v = cfg_rsp.rdata;
   endtask : bus
   task automatic wr(input logic fn, input logic [7:0] ofs, input logic [7:0] wd);
      bus(fn, ofs, 1'b1, wd);
   endtask : wr
   task automatic rdchk(input string nm, input logic fn, input logic [7:0] ofs,
         input logic [7:0] ex);
      bus(fn, ofs, 1'b0, 8'h00);
      chk(nm, rd_v, ex);
   endtask : rdchk
   task automatic settle();
      repeat (6) @(posedge clk_sys);
      #1;
   endtask : settle
   function automatic logic [7:0] cc_exp(input logic r, input logic [7:0] c);
      return {r, c[6:5], 2'b00, c[2:1], 1'b0};
   endfunction : cc_exp
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      stop_test();
   end
   initial begin
      void'($urandom(30));
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      #1;
      chk("lv_rst", lv, 1'b1);
      chk("mode_rst", mode, 2'b11);
      chk("ring_rst", ring_oe, 1'b0);
      for (int i = 0; i < 2; i++) begin
         rdchk("cc_rst", i[0], 8'h91, 8'h00);
         rdchk("dc_rst", i[0], 8'h92, 8'h66);
      end
      rdchk("unmapped", 1'b0, 8'h93, 8'h00);
      ring_en = 1'b0;
      cc0 = '0;
      cc1 = '0;
      for (int i = 0; i < 12; i++) begin
         f = 1'($urandom);
         d = 8'($urandom);
         wr(f, 8'h91, d);
         if (f) cc1 = d;
         else begin
            cc0 = d;
            ring_en = d[7];
         end
         rdchk("cc0", 1'b0, 8'h91, cc_exp(ring_en, cc0));
         rdchk("cc1", 1'b1, 8'h91, cc_exp(ring_en, cc1));
         chk("vfloat", vfloat, {cc1[6], cc0[6]});
      end
      lv_m = 1'b1;
      for (int i = 0; i < 8; i++) begin
         f = 1'($urandom);
         // Test bits 3 and 0 are only ever written as 0
         d = (8'($urandom) & 8'hF0) | {5'h00, i[1:0], 1'b0};
         wr(f, 8'h92, d);
         if (!f) lv_m = d[6];
         diag_m = d[5];
         rdchk("dc", !f, 8'h92, {1'b0, lv_m, diag_m, 2'b00, i[1:0], 1'b0});
         chk("mode", mode, i[1:0]);
         chk("lv", lv, lv_m);
         chk("diag", diag, diag_m);
         chk("tst", {vtest, rtest}, 2'b00);
      end
      wr(1'b0, 8'h91, 8'h00);
      wr(1'b1, 8'h91, 8'h00);
      for (int s = 0; s < 2; s++) begin
         @(posedge clk_sys) irq_lvl[s] <= 1'b1;
         rd_v = '0;
         for (k = 0; k < 8 && rd_v[0] !== 1'b1; k++) bus(s[0], 8'h91, 1'b0, 8'h00);
         chk("flag_set", rd_v[0], 1'b1);
         if (rd_v[0] !== 1'b1) stop_test();
         rdchk("flag_other", !s[0], 8'h91, 8'h00);
         wr(s[0], 8'h91, 8'h00);
         rdchk("flag_keep", s[0], 8'h91, 8'h01);
         wr(s[0], 8'h91, 8'h01);
         rdchk("flag_clr", s[0], 8'h91, 8'h00);
         @(posedge clk_sys) irq_lvl[s] <= 1'b0;
      end
      for (int c = 0; c < 4; c++) begin
         wr(1'b0, 8'h91, {6'h00, c[0], 1'b0});
         wr(1'b1, 8'h91, {6'h00, c[1], 1'b0});
         for (int j = 0; j < 3; j++) begin
            @(posedge clk_sys) spk_lvl <= 2'($urandom);
            settle();
            chk("spk_oe", spk_oe, c != 0);
            chk("spk", spk_o, ^(spk_lvl & c[1:0]));
         end
      end
      @(posedge clk_sys) begin
         mf2 <= 4'h8;
         mf4 <= 4'h8;
      end
      wr(1'b0, 8'h91, 8'h04);
      wr(1'b1, 8'h91, 8'h04);
      for (int j = 0; j < 4; j++) begin
         @(posedge clk_sys) aud_lvl <= j[1:0];
         settle();
         chk("aud_both", {m2_o, m4_o}, {2{j[0]}});
         chk("aud_oe", {m2_oe, m4_oe}, 2'b11);
      end
      wr(1'b0, 8'h91, 8'h00);
      @(posedge clk_sys) aud_lvl <= 2'b10;
      settle();
      chk("aud_s1", m4_o, 1'b1);
      @(posedge clk_sys) begin
         ring_indicate_src <= 1'b1;
         mf2 <= 4'hC;
         mf4 <= 4'hC;
      end
      wr(1'b1, 8'h91, 8'h80);
      settle();
      chk("ring_fn1", {ring_oe, m2_oe, m4_oe}, 3'b000);
      wr(1'b0, 8'h91, 8'hE0);
      wr(1'b1, 8'h91, 8'h40);
      settle();
      chk("ring", {ring_oe, ring_o, m2_oe, m2_o}, 4'hF);
      chk("ring4", {m4_oe, m4_o}, 2'b11);
      chk("vsel1", {vs0_b, vs1_b}, 2'b10);
      @(posedge clk_sys) ring_pme_select <= 1'b1;
      settle();
      chk("ring_mux", {ring_oe, m2_oe, m4_oe}, 3'b011);
      wr(1'b0, 8'h91, 8'h40);
      settle();
      chk("ring_off", {ring_oe, m2_oe, m4_oe}, 3'b000);
      chk("vsel0", {vs0_b, vs1_b}, 2'b01);
      stop_test();
   end
endmodule : scdc_top_tb
